// ### verilog/acc_pkg.sv
// Purpose: shared constants and types for the analog comparator control block
// Assumes: APB slave with 32-bit data, 12-bit byte address inside the block
// Notes:   field layouts below are fixed for this block; see each group
package acc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [11:0] OFF_START_TASK     = 12'h000;
   localparam logic [11:0] OFF_STOP_TASK      = 12'h004;
   localparam logic [11:0] OFF_SAMPLE_TASK    = 12'h008;
   localparam logic [11:0] OFF_READY_EVENT    = 12'h100;
   localparam logic [11:0] OFF_DOWNWARD_EVENT = 12'h104;
   localparam logic [11:0] OFF_UPWARD_EVENT   = 12'h108;
   localparam logic [11:0] OFF_CROSSING_EVENT = 12'h10C;
   localparam logic [11:0] OFF_EVENT_LINKS    = 12'h200;
   localparam logic [11:0] OFF_IRQ_MASK       = 12'h300;
   localparam logic [11:0] OFF_IRQ_MASK_SET   = 12'h304;
   localparam logic [11:0] OFF_IRQ_MASK_CLR   = 12'h308;
   localparam logic [11:0] OFF_RESULT         = 12'h400;
   localparam logic [11:0] OFF_ENABLE         = 12'h500;
   localparam logic [11:0] OFF_POS_SELECT     = 12'h504;
   localparam logic [11:0] OFF_REF_SOURCE     = 12'h508;
   localparam logic [11:0] OFF_OUTSIDE_PIN    = 12'h50C;
   localparam logic [11:0] OFF_LADDER_LIMITS  = 12'h530;
   localparam logic [11:0] OFF_OPER_CONFIG    = 12'h534;
   localparam logic [11:0] OFF_NOISE_BAND     = 12'h538;

   ////////////////////////////////////////////////////////////////////////////
   // event indices, shared by event flags and interrupt mask bits
   localparam int EV_READY = 0;
   localparam int EV_DOWN  = 1;
   localparam int EV_UP    = 2;
   localparam int EV_CROSS = 3;
   localparam int EV_NUM   = 4;

   // field positions
   localparam int LINK_READY_SAMPLE = 0;
   localparam int CFG_SPEED_LSB     = 0;
   localparam int CFG_DIFF_BIT      = 8;
   localparam int LIM_LOWER_LSB     = 0;
   localparam int LIM_UPPER_LSB     = 8;
   localparam int CODE_W            = 6;   // 64-level ladder
   localparam int SEL_W             = 3;

   // reset values
   localparam logic [31:0] RST_WORD   = 32'h0000_0000;
   localparam logic [1:0]  RST_SPEED  = 2'h0;
   localparam logic [2:0]  RST_SEL    = 3'h0;
   localparam logic [5:0]  RST_CODE   = 6'h00;

   // reference source codes; codes up to REF_INT_MAX are internal references
   localparam logic [2:0] REF_INT_1V2   = 3'h0;
   localparam logic [2:0] REF_INT_1V8   = 3'h1;
   localparam logic [2:0] REF_INT_2V4   = 3'h2;
   localparam logic [2:0] REF_INT_MAX   = 3'h2;
   localparam logic [2:0] REF_MAIN_SUPP = 3'h4;
   localparam logic [2:0] REF_ANA_PIN   = 3'h5;

   // speed settings
   localparam logic [1:0] SPD_LOW_POWER = 2'h0;
   localparam logic [1:0] SPD_NORMAL    = 2'h1;
   localparam logic [1:0] SPD_HIGH      = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // start-up timing
   localparam int CLK_PERIOD_NS       = 40;
   localparam int T_INT_REF_START_NS  = 10000;
   localparam int T_COMP_START_NS     = 500;
   localparam int INT_REF_START_CYC   =
      (T_INT_REF_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COMP_START_CYC      =
      (T_COMP_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // controls toward the analog core
   typedef struct packed {
      logic             pins_taken;     // analog pins acquired
      logic             core_on;        // core powered and comparing
      logic             diff_mode;      // 1 differential, 0 single-ended
      logic [1:0]       speed;
      logic [SEL_W-1:0] pos_sel;        // 0..6 pins, 7 divided high supply
      logic [SEL_W-1:0] ref_src;
      logic [SEL_W-1:0] outside_pin;
      logic [CODE_W-1:0] ladder_code;   // active ladder level
      logic             noise_band_en;
   } acc_ana_ctl_t;

   typedef enum logic [2:0] {
      ST_OFF  = 3'b001,
      ST_WARM = 3'b010,
      ST_RUN  = 3'b100
   } acc_state_t;

endpackage

// ### verilog/acc_start_timer.sv
// Purpose: start-up delay counter for the comparator core
// Assumes: i_load is a one-cycle pulse; i_abort may be held high
// Notes:   o_done is a registered one-cycle pulse
`timescale 1ns/100ps
module acc_start_timer
   #(parameter int CNT_W = 16)
   (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_load,
   input  wire logic [CNT_W-1:0] i_count,
   input  wire logic             i_abort,
   output logic                  o_done
   );

   logic [CNT_W-1:0] cnt_reg;
   logic             busy_reg;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_reg  <= '0;
         busy_reg <= 1'b0;
         o_done   <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         if (i_abort)
            busy_reg <= 1'b0;
         else if (i_load)
         begin
            cnt_reg  <= i_count;
            busy_reg <= 1'b1;
         end
         else if (busy_reg)
         begin
            if (cnt_reg <= CNT_W'(1))
            begin
               busy_reg <= 1'b0;
               o_done   <= 1'b1;
            end
            else
               cnt_reg <= cnt_reg - CNT_W'(1);
         end
      end
   end

endmodule // acc_start_timer

// ### verilog/acc_comparator_ctrl.sv
// Purpose: register, task and event logic around a voltage comparator core
// Assumes: APB slave, no wait states; comparator decision synchronous to I_CLOCK
// Notes:   the analog core, ladder and references live outside this block
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module acc_comparator_ctrl
   import acc_pkg::*;
   #(parameter int INT_REF_CYC = INT_REF_START_CYC,
     parameter int COMP_CYC    = COMP_START_CYC,
     parameter int CNT_W       = 16)
   (
   input  wire logic          I_CLOCK,
   input  wire logic          I_SYS_RST,
   input  wire logic          I_PSEL,
   input  wire logic          I_PENABLE,
   input  wire logic          I_PWRITE,
   input  wire logic [11:0]   I_PADDR,
   input  wire logic [31:0]   I_PWDATA,
   output logic      [31:0]   O_PRDATA,
   output logic               O_PREADY,
   output logic               O_PSLVERR,
   input  wire logic          I_CMP_DECISION,
   output acc_ana_ctl_t       O_ANA_CTL,
   output logic               O_IRQ
   );

   ////////////////////////////////////////////////////////////////////////////
   // state
   acc_state_t         state_reg;
   logic               enable_reg;
   logic [1:0]         speed_reg;
   logic               diff_reg;
   logic [SEL_W-1:0]   pos_sel_reg;
   logic [SEL_W-1:0]   ref_src_reg;
   logic [SEL_W-1:0]   out_pin_reg;
   logic [CODE_W-1:0]  upper_code_reg;
   logic [CODE_W-1:0]  lower_code_reg;
   logic               noise_band_reg;
   logic               link_ready_sample_reg;
   logic [EV_NUM-1:0]  event_reg;
   logic [EV_NUM-1:0]  mask_reg;
   logic               result_reg;
   logic               decision_prev_reg;
   logic               timer_done;
   logic [EV_NUM-1:0]  ev_set;
   logic               wr_access;
   logic               setup;
   logic               start_pulse;
   logic               stop_pulse;
   logic               sample_pulse;
   logic [CNT_W-1:0]   start_count;
   logic               halt;
   logic               timer_load;

   function automatic logic addr_known(input logic [11:0] a);
      unique case (a)
         OFF_START_TASK, OFF_STOP_TASK, OFF_SAMPLE_TASK, OFF_READY_EVENT,
         OFF_DOWNWARD_EVENT, OFF_UPWARD_EVENT, OFF_CROSSING_EVENT,
         OFF_EVENT_LINKS, OFF_IRQ_MASK, OFF_IRQ_MASK_SET, OFF_IRQ_MASK_CLR,
         OFF_RESULT, OFF_ENABLE, OFF_POS_SELECT, OFF_REF_SOURCE,
         OFF_OUTSIDE_PIN, OFF_LADDER_LIMITS, OFF_OPER_CONFIG, OFF_NOISE_BAND:
            addr_known = 1'b1;
         default:
            addr_known = 1'b0;
      endcase
   endfunction

   function automatic logic wr_hit(input logic [11:0] off);
      wr_hit = wr_access && (I_PADDR == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // apb handshake: no wait state; read data and error come from flops loaded in setup
   assign setup     = I_PSEL && !I_PENABLE;
   assign wr_access = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE
                      && addr_known(I_PADDR);

   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
      end
      else
      begin
         O_PREADY  <= setup;
         // unmapped addresses answer with an error and are never written
         O_PSLVERR <= setup && !addr_known(I_PADDR);
      end
   end

   // read data is taken in the setup cycle, so a flag set in the access
   // cycle shows up on the next read
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         O_PRDATA <= RST_WORD;
      else if (setup && !I_PWRITE)
      begin
         O_PRDATA <= RST_WORD;
         unique case (I_PADDR)
            OFF_READY_EVENT:    O_PRDATA[0] <= event_reg[EV_READY];
            OFF_DOWNWARD_EVENT: O_PRDATA[0] <= event_reg[EV_DOWN];
            OFF_UPWARD_EVENT:   O_PRDATA[0] <= event_reg[EV_UP];
            OFF_CROSSING_EVENT: O_PRDATA[0] <= event_reg[EV_CROSS];
            OFF_EVENT_LINKS:    O_PRDATA[LINK_READY_SAMPLE] <= link_ready_sample_reg;
            OFF_IRQ_MASK, OFF_IRQ_MASK_SET, OFF_IRQ_MASK_CLR:
               O_PRDATA[EV_NUM-1:0] <= mask_reg;
            OFF_RESULT:         O_PRDATA[0] <= result_reg;
            OFF_ENABLE:         O_PRDATA[0] <= enable_reg;
            OFF_POS_SELECT:     O_PRDATA[SEL_W-1:0] <= pos_sel_reg;
            OFF_REF_SOURCE:     O_PRDATA[SEL_W-1:0] <= ref_src_reg;
            OFF_OUTSIDE_PIN:    O_PRDATA[SEL_W-1:0] <= out_pin_reg;
            OFF_LADDER_LIMITS:
            begin
               O_PRDATA[LIM_LOWER_LSB +: CODE_W] <= lower_code_reg;
               O_PRDATA[LIM_UPPER_LSB +: CODE_W] <= upper_code_reg;
            end
            OFF_OPER_CONFIG:
            begin
               O_PRDATA[CFG_SPEED_LSB +: 2] <= speed_reg;
               O_PRDATA[CFG_DIFF_BIT]       <= diff_reg;
            end
            OFF_NOISE_BAND:     O_PRDATA[0] <= noise_band_reg;
            default:            O_PRDATA <= RST_WORD;  // tasks read as zero
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // tasks
   assign start_pulse  = wr_hit(OFF_START_TASK) && I_PWDATA[0];
   assign stop_pulse   = wr_hit(OFF_STOP_TASK) && I_PWDATA[0];
   assign sample_pulse = (wr_hit(OFF_SAMPLE_TASK) && I_PWDATA[0])
                         || (ev_set[EV_READY] && link_ready_sample_reg);

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         enable_reg            <= 1'b0;
         speed_reg             <= RST_SPEED;
         diff_reg              <= 1'b0;
         pos_sel_reg           <= RST_SEL;
         ref_src_reg           <= RST_SEL;
         out_pin_reg           <= RST_SEL;
         upper_code_reg        <= RST_CODE;
         lower_code_reg        <= RST_CODE;
         link_ready_sample_reg <= 1'b0;
      end
      else
      begin
         if (wr_hit(OFF_ENABLE))
            enable_reg <= I_PWDATA[0];
         if (wr_hit(OFF_OPER_CONFIG))
         begin
            speed_reg <= I_PWDATA[CFG_SPEED_LSB +: 2];
            diff_reg  <= I_PWDATA[CFG_DIFF_BIT];
         end
         if (wr_hit(OFF_POS_SELECT))
            pos_sel_reg <= I_PWDATA[SEL_W-1:0];
         if (wr_hit(OFF_REF_SOURCE))
            ref_src_reg <= I_PWDATA[SEL_W-1:0];
         if (wr_hit(OFF_OUTSIDE_PIN))
            out_pin_reg <= I_PWDATA[SEL_W-1:0];
         if (wr_hit(OFF_LADDER_LIMITS))
         begin
            lower_code_reg <= I_PWDATA[LIM_LOWER_LSB +: CODE_W];
            upper_code_reg <= I_PWDATA[LIM_UPPER_LSB +: CODE_W];
         end
         if (wr_hit(OFF_EVENT_LINKS))
            link_ready_sample_reg <= I_PWDATA[LINK_READY_SAMPLE];
      end
   end

   // writes in single-ended mode are dropped, and the stored bit is masked
   // on the way to the core, so a mode change never lets a stale value reach the core
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         noise_band_reg <= 1'b0;
      else if (wr_hit(OFF_NOISE_BAND) && diff_reg)
         noise_band_reg <= I_PWDATA[0];
   end

   // mask register and its set-only and clear-only aliases
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         mask_reg <= '0;
      else if (wr_hit(OFF_IRQ_MASK))
         mask_reg <= I_PWDATA[EV_NUM-1:0];
      else if (wr_hit(OFF_IRQ_MASK_SET))
         mask_reg <= mask_reg | I_PWDATA[EV_NUM-1:0];
      else if (wr_hit(OFF_IRQ_MASK_CLR))
         mask_reg <= mask_reg & ~I_PWDATA[EV_NUM-1:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // run control
   assign start_count = (ref_src_reg <= REF_INT_MAX) ?
                        CNT_W'(INT_REF_CYC) : CNT_W'(COMP_CYC);

   // stop or disable wins over a start, and aborts a warm-up in progress
   assign halt       = !enable_reg || stop_pulse;
   assign timer_load = start_pulse && enable_reg && (state_reg == ST_OFF);

   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         state_reg <= ST_OFF;
      else if (halt)
         state_reg <= ST_OFF;
      else
      begin
         // a start while warming or running is ignored
         unique case (state_reg)
            ST_OFF:  if (start_pulse) state_reg <= ST_WARM;
            ST_WARM: if (timer_done)  state_reg <= ST_RUN;
            ST_RUN:  state_reg <= ST_RUN;
            default: state_reg <= ST_OFF;
         endcase
      end
   end

   acc_start_timer #(.CNT_W(CNT_W)) u_start_timer
   (
      .i_clk   (I_CLOCK),
      .i_rst   (I_SYS_RST),
      .i_load  (timer_load),
      .i_count (start_count),
      .i_abort (halt),
      .o_done  (timer_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // events
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         decision_prev_reg <= 1'b0;
      else
         decision_prev_reg <= I_CMP_DECISION;
   end

   always_comb
   begin
      ev_set            = '0;
      ev_set[EV_READY]  = timer_done && (state_reg == ST_WARM)
                          && !halt;
      if (state_reg == ST_RUN)
      begin
         ev_set[EV_UP]    = I_CMP_DECISION && !decision_prev_reg;
         ev_set[EV_DOWN]  = !I_CMP_DECISION && decision_prev_reg;
         ev_set[EV_CROSS] = I_CMP_DECISION != decision_prev_reg;
      end
   end

   // a set in the same cycle as a software clear wins
   for (genvar g = 0; g < EV_NUM; g++)
   begin : g_event
      always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
      begin
         if (I_SYS_RST)
            event_reg[g] <= 1'b0;
         else if (ev_set[g])
            event_reg[g] <= 1'b1;
         else if (wr_hit(OFF_READY_EVENT + 12'(4 * g)))
            event_reg[g] <= I_PWDATA[0];
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         O_IRQ <= 1'b0;
      else
         O_IRQ <= |(event_reg & mask_reg);
   end

   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         result_reg <= 1'b0;
      else if (sample_pulse)
         result_reg <= I_CMP_DECISION;
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog controls
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
         O_ANA_CTL <= '0;
      else
      begin
         O_ANA_CTL.pins_taken    <= enable_reg;
         // gated by enable so the core never runs a cycle after the pins
         // are released on a disable while started
         O_ANA_CTL.core_on       <= (state_reg != ST_OFF) && enable_reg;
         O_ANA_CTL.diff_mode     <= diff_reg;
         O_ANA_CTL.speed         <= speed_reg;
         O_ANA_CTL.pos_sel       <= pos_sel_reg;
         O_ANA_CTL.ref_src       <= ref_src_reg;
         O_ANA_CTL.outside_pin   <= out_pin_reg;
         // ladder follows the registered decision; two cycles of lag are far below
         // any core response time
         O_ANA_CTL.ladder_code   <= decision_prev_reg ?
                                    lower_code_reg : upper_code_reg;
         O_ANA_CTL.noise_band_en <= noise_band_reg && diff_reg;
      end
   end

endmodule // acc_comparator_ctrl

// ### bench/acc_ctrl_assertions.sv
// Purpose: port-level checks for acc_comparator_ctrl
// Assumes: one clock, async active-high reset
// Notes:   ladder limits are tracked from accepted bus writes
`timescale 1ns/100ps
module acc_ctrl_assertions
   import acc_pkg::*;
   (
   input wire logic          I_CLOCK,
   input wire logic          I_SYS_RST,
   input wire logic          I_PSEL,
   input wire logic          I_PENABLE,
   input wire logic          I_PWRITE,
   input wire logic [11:0]   I_PADDR,
   input wire logic [31:0]   I_PWDATA,
   input wire logic [31:0]   O_PRDATA,
   input wire logic          O_PREADY,
   input wire logic          O_PSLVERR,
   input wire logic          I_CMP_DECISION,
   input wire acc_ana_ctl_t  O_ANA_CTL,
   input wire logic          O_IRQ
   );
   logic [5:0] lim_up_reg;
   logic [5:0] lim_lo_reg;
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge I_CLOCK or posedge I_SYS_RST)
   begin
      if (I_SYS_RST)
      begin
         lim_up_reg <= 6'h00;
         lim_lo_reg <= 6'h00;
      end
      else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == OFF_LADDER_LIMITS)
      begin
         lim_up_reg <= I_PWDATA[13:8];
         lim_lo_reg <= I_PWDATA[5:0];
      end
   end
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);
   ////////////////////////////////////////////////////////////////////////////
   chk_setup_ready: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
      else $error("no ready after setup");
   chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");
   chk_unmapped_err: assert property (O_PREADY && I_PADDR == 12'h00C
      |-> O_PSLVERR && (I_PWRITE || O_PRDATA == 32'h0)) else $error("unmapped not refused");
   chk_task_read_zero: assert property (O_PREADY && !I_PWRITE && I_PADDR == OFF_START_TASK
      |-> O_PRDATA == 32'h0 && !O_PSLVERR) else $error("task read not zero");
   chk_core_needs_pins: assert property (O_ANA_CTL.core_on |-> O_ANA_CTL.pins_taken)
      else $error("core on without pins");
   chk_pins_on_enable: assert property ($rose(O_ANA_CTL.pins_taken)
      |-> $past(I_PWRITE && I_PADDR == OFF_ENABLE) || $past(I_PWRITE && I_PADDR == OFF_ENABLE, 2))
      else $error("pins taken without enable write");
   chk_ladder_low: assert property (O_ANA_CTL.core_on && !O_ANA_CTL.diff_mode
      && $past(I_CMP_DECISION) && $past(I_CMP_DECISION, 2) && $past(I_CMP_DECISION, 3)
      |-> O_ANA_CTL.ladder_code == lim_lo_reg) else $error("above but not lower level");
   chk_ladder_high: assert property (O_ANA_CTL.core_on && !O_ANA_CTL.diff_mode
      && !$past(I_CMP_DECISION) && !$past(I_CMP_DECISION, 2) && !$past(I_CMP_DECISION, 3)
      |-> O_ANA_CTL.ladder_code == lim_up_reg) else $error("below but not upper level");
endmodule // acc_ctrl_assertions

bind acc_comparator_ctrl acc_ctrl_assertions acc_ctrl_assertions_inst (.I_CLOCK(I_CLOCK),
   .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
   .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
   .O_PSLVERR(O_PSLVERR), .I_CMP_DECISION(I_CMP_DECISION), .O_ANA_CTL(O_ANA_CTL),
   .O_IRQ(O_IRQ));

// ### bench/tb_top.sv
// Purpose: self-checking bench for acc_comparator_ctrl
// Assumes: short start-up counts (3 internal, 2 external)
// Notes:   checks sampled at negedge to stay clear of update races
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
   import acc_pkg::*;
   localparam int TB_INT_CYC  = 3;
   localparam int TB_COMP_CYC = 2;
   logic         clk;
   logic         rst;
   logic         psel;
   logic         pen;
   logic         pwr;
   logic         dec;
   logic [11:0]  paddr;
   logic [31:0]  pwdata;
   logic [31:0]  prdata;
   logic [31:0]  rdata;
   logic         pready;
   logic         pslverr;
   logic         err;
   logic         irq;
   acc_ana_ctl_t ana;
   int           fail_count = 0;
   int           n_compared = 0;
   int           cyc = 0;
   int           n;
   int           ev[4];
   logic [31:0]  v;
   logic [2:0]   refs[3] = '{REF_INT_1V8, REF_ANA_PIN, REF_MAIN_SUPP};
   logic [11:0]  offs[9] = '{OFF_START_TASK, OFF_READY_EVENT, OFF_DOWNWARD_EVENT,
      OFF_UPWARD_EVENT, OFF_CROSSING_EVENT, OFF_EVENT_LINKS, OFF_IRQ_MASK, OFF_RESULT, OFF_ENABLE};
   ////////////////////////////////////////////////////////////////////////////
   acc_comparator_ctrl #(.INT_REF_CYC(TB_INT_CYC), .COMP_CYC(TB_COMP_CYC))
   acc_comparator_ctrl_inst (
      .I_CLOCK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_CMP_DECISION(dec), .O_ANA_CTL(ana), .O_IRQ(irq));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // two idle cycles between transfers; returns at a negedge so outputs have settled
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(negedge clk);
      @(negedge clk);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdata, e)
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst, psel, pen, pwr, dec, paddr, pwdata} = '0;
      rst = 1'b1;
      void'($urandom(32'h450B));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (offs[i]) rd_chk(offs[i], 32'h0);
      apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
      `CHK(err, 1'b1)
      rd_chk(12'h00C, 32'h0);
      `CHK(err, 1'b1)
      $display("test reset_and_map done");
      apb(1'b1, OFF_IRQ_MASK, 32'h5);
      apb(1'b1, OFF_IRQ_MASK_SET, 32'h8);
      rd_chk(OFF_IRQ_MASK_CLR, 32'hD);
      apb(1'b1, OFF_IRQ_MASK_CLR, 32'h1);
      rd_chk(OFF_IRQ_MASK_SET, 32'hC);
      for (int s = 0; s < 3; s++)
      begin
         apb(1'b1, OFF_OPER_CONFIG, 32'h100 | s);
         `CHK({ana.diff_mode, ana.speed}, {1'b1, s[1:0]})
      end
      apb(1'b1, OFF_NOISE_BAND, 32'h1);
      `CHK(ana.noise_band_en, 1'b1)
      apb(1'b1, OFF_NOISE_BAND, 32'h0);
      apb(1'b1, OFF_OPER_CONFIG, 32'h1);
      apb(1'b1, OFF_NOISE_BAND, 32'h1);
      rd_chk(OFF_NOISE_BAND, 32'h0);
      v = $urandom;
      apb(1'b1, OFF_POS_SELECT, {29'h0, v[2:0]});
      apb(1'b1, OFF_OUTSIDE_PIN, {29'h0, v[5:3]});
      apb(1'b1, OFF_LADDER_LIMITS, {18'h0, v[13:8], 2'h0, v[21:16]});
      `CHK({ana.pos_sel, ana.outside_pin}, {v[2:0], v[5:3]})
      apb(1'b1, OFF_START_TASK, 32'h1);
      `CHK(ana.core_on, 1'b0)
      rd_chk(OFF_READY_EVENT, 32'h0);
      apb(1'b1, OFF_ENABLE, 32'h1);
      `CHK({ana.pins_taken, ana.core_on}, 2'b10)
      apb(1'b1, OFF_EVENT_LINKS, 32'h1);
      apb(1'b1, OFF_IRQ_MASK, 32'h1);
      $display("test config done");
      foreach (refs[i])
      begin
         @(posedge clk);
         dec <= refs[i][0];
         apb(1'b1, OFF_ENABLE, 32'h0);
         apb(1'b1, OFF_REF_SOURCE, {29'h0, refs[i]});
         apb(1'b1, OFF_ENABLE, 32'h1);
         `CHK(ana.ref_src, refs[i])
         apb(1'b1, OFF_START_TASK, 32'h1);
         n = 1;
         while (irq !== 1'b1 && n < 50)
         begin
            @(negedge clk);
            n++;
         end
         `CHK(n, (refs[i] <= REF_INT_MAX) ? TB_INT_CYC + 2 : TB_COMP_CYC + 2)
         `CHK(ana.core_on, 1'b1)
         rd_chk(OFF_READY_EVENT, 32'h1);
         rd_chk(OFF_RESULT, {31'h0, refs[i][0]});
         apb(1'b1, OFF_READY_EVENT, 32'h0);
         `CHK(irq, 1'b0)
         if (i < 2) apb(1'b1, OFF_STOP_TASK, 32'h1);
         if (i < 2) `CHK(ana.core_on, 1'b0)
      end
      $display("test start_ready done");
      apb(1'b1, OFF_IRQ_MASK, 32'hE);
      ev = '{0, 0, 0, 0};
      for (int j = 0; j < 16; j++)
      begin
         v = $urandom;
         @(posedge clk);
         dec <= v[0];
         if (v[0] !== dec) ev[3] = 1;
         if (v[0] !== dec) ev[v[0] ? 2 : 1] = 1;
         repeat (3) @(negedge clk);
         `CHK(irq, 1'(ev[1] | ev[2] | ev[3]))
      end
      for (int e = 1; e < 4; e++) rd_chk(OFF_READY_EVENT + 12'(4 * e), 32'(ev[e]));
      for (int e = 1; e < 4; e++) apb(1'b1, OFF_READY_EVENT + 12'(4 * e), 32'h0);
      `CHK(irq, 1'b0)
      $display("test events done");
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk);
         dec <= s[0];
         apb(1'b1, OFF_SAMPLE_TASK, 32'h1);
         @(posedge clk);
         dec <= ~s[0];
         apb(1'b1, OFF_SAMPLE_TASK, 32'h0);
         rd_chk(OFF_RESULT, 32'(s));
      end
      apb(1'b1, OFF_STOP_TASK, 32'h1);
      apb(1'b1, OFF_CROSSING_EVENT, 32'h0);
      @(posedge clk);
      dec <= ~dec;
      rd_chk(OFF_CROSSING_EVENT, 32'h0);
      apb(1'b1, OFF_ENABLE, 32'h0);
      `CHK(ana.pins_taken, 1'b0)
      $display("test sample_stop done");
      tally_and_finish();
   end
endmodule // tb_top
